// ### rtl/tmc_timer.sv
// Sixteen-bit timer/counter with prescaler, pin synchronisation and APB registers
`timescale 1ns/1ns
module tmc_timer
    import tmc_pkg::*;
(
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    // APB slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [APB_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Pins and system
    input  wire logic                  i_ext_clock_pin,
    input  wire logic                  i_osc_input_pin,
    input  wire logic                  i_sleep,
    input  wire logic                  i_special_event,
    output logic                       o_osc_run,
    output logic                       o_pins_as_inputs,
    output logic                       o_osc_output_pin,
    output logic                       o_osc_output_pin_oe_n,
    output logic                       o_overflow_irq,
    output logic                       o_wake,
    output logic                       o_timebase_valid,
    output logic      [15:0]           o_count
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [CTL_W-1:0]      ctrl;
    logic [15:0]           count;
    logic                  overflow_flag;
    logic                  overflow_irq_enable;
    logic [PRESCALE_W-1:0] prescale_cnt;
    logic [1:0]            pin_sync;
    logic                  src_prev;
    logic                  smp_level;
    tmc_phase_t            phase;
    tmc_phase_t            next_phase;

    logic                  timer_on_bit;
    logic                  clock_source_select;
    logic                  sync_disable_bit;
    logic                  osc_enable_bit;
    logic [1:0]            prescale_select;
    logic                  async_mode;
    logic                  src_level;
    logic                  pin_rise;
    logic                  inst_tick;
    logic                  src_event;
    logic [PRESCALE_W-1:0] ps_mask;
    logic                  ps_pulse;
    logic                  ps_level;
    logic                  sample_now;
    logic                  sync_inc;
    logic                  inc;
    logic                  wr_access;
    logic                  wr_low;
    logic                  wr_high;
    logic                  wr_count;
    logic                  special_clear;
    logic                  overflow_set;
    logic                  addr_mapped;
    logic [31:0]           next_prdata;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address decode, used by both read and write paths
    function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                     input logic [7:0]            idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    // Level of the selected prescaler stage; 1:1 passes the source through
    function automatic logic stage_level(input logic [1:0]            sel,
                                         input logic [PRESCALE_W-1:0] cnt,
                                         input logic                  src);
        unique case (sel)
            2'b00: stage_level = src;
            2'b01: stage_level = cnt[0];
            2'b10: stage_level = cnt[1];
            2'b11: stage_level = cnt[2];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control field views

    assign timer_on_bit        = ctrl[CTL_TIMER_ON_BIT];
    assign clock_source_select = ctrl[CTL_CLOCK_SOURCE_SELECT];
    assign sync_disable_bit    = ctrl[CTL_SYNC_DISABLE_BIT];
    assign osc_enable_bit      = ctrl[CTL_OSC_ENABLE_BIT];
    assign prescale_select     = ctrl[CTL_PRESCALE_MSB:CTL_PRESCALE_LSB];
    // Sync bit only matters in counter mode
    assign async_mode          = clock_source_select & sync_disable_bit;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and source selection

    // Both pins are asynchronous to the system clock
    tmc_pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_async   ({i_osc_input_pin, i_ext_clock_pin}),
        .o_sync    (pin_sync)
    );

    // Oscillator pin when the oscillator runs, external pin otherwise
    assign src_level = osc_enable_bit ? pin_sync[1] : pin_sync[0];
    assign pin_rise  = src_level & ~src_prev;

    // Previous source level for rising edge detection
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            src_prev <= 1'b0;
        end else if (i_ce) begin
            src_prev <= src_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal phase clocks Q1..Q4

    always_comb begin
        unique case (phase)
            PH_Q1: next_phase = PH_Q2;
            PH_Q2: next_phase = PH_Q3;
            PH_Q3: next_phase = PH_Q4;
            PH_Q4: next_phase = PH_Q1;
            default: next_phase = PH_Q1;
        endcase
    end

    // Phase clocks stop in sleep, as the core clock does
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            phase <= PH_Q1;
        end else if (i_ce && !i_sleep) begin
            phase <= next_phase;
        end
    end

    // One tick per instruction cycle, at the end of Q4
    assign inst_tick = (phase == PH_Q4) & ~i_sleep;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler

    // Timer mode counts instruction ticks, counter mode counts pin edges
    assign src_event = timer_on_bit
                     & (clock_source_select ? pin_rise : inst_tick);

    always_comb begin
        unique case (prescale_select)
            2'b00: ps_mask = 3'h0;
            2'b01: ps_mask = 3'h1;
            2'b10: ps_mask = 3'h3;
            2'b11: ps_mask = 3'h7;
        endcase
    end

    // Edge count that completes the selected ratio
    assign ps_pulse = src_event & ((prescale_cnt & ps_mask) == ps_mask);
    // Symmetric prescaler output level seen by the synchroniser
    assign ps_level = stage_level(prescale_select, prescale_cnt, src_level);

    // Keeps counting edges in sleep; count writes clear it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            prescale_cnt <= PRESCALE_RESET;
        end else if (i_ce) begin
            if (wr_count) begin
                prescale_cnt <= PRESCALE_RESET;
            end else if (src_event) begin
                prescale_cnt <= prescale_cnt + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser after the prescaler

    // Sampling happens on Q2 and Q4 only, and is shut off in sleep
    assign sample_now = ((phase == PH_Q2) | (phase == PH_Q4)) & ~i_sleep;
    assign sync_inc   = sample_now & ps_level & ~smp_level;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            smp_level <= 1'b0;
        end else if (i_ce && sample_now) begin
            smp_level <= ps_level;
        end
    end

    // Unsynchronised mode bumps on the prescaler pulse, even in sleep
    always_comb begin
        if (!timer_on_bit) begin
            inc = 1'b0;
        end else if (!clock_source_select || async_mode) begin
            inc = ps_pulse;
        end else begin
            inc = sync_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    assign wr_access = i_psel & i_penable & i_pwrite & i_ce;
    assign wr_low    = wr_access & reg_hit(i_paddr, IDX_COUNT_LOW_BYTE);
    assign wr_high   = wr_access & reg_hit(i_paddr, IDX_COUNT_HIGH_BYTE);
    assign wr_count  = wr_low | wr_high;

    // Trigger clear may fail in async mode, so it is simply ignored there
    assign special_clear = i_special_event & ~async_mode & ~wr_count;

    // Overflow only from a real increment, never from a clear
    assign overflow_set = inc & ~wr_count & ~special_clear
                        & (count == COUNT_ALL_ONES);

    // Control register, cleared only by power-on reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl <= CTL_RESET;
        end else if (wr_access && reg_hit(i_paddr, IDX_TIMER_ONE_CONTROL)) begin
            ctrl <= i_pwdata[CTL_W-1:0];
        end
    end

    // Count has no reset; a write beats both clear and increment
    always_ff @(posedge i_clk_sys) begin
        if (i_ce) begin
            if (wr_count) begin
                if (wr_low) begin
                    count[7:0] <= i_pwdata[7:0];
                end
                if (wr_high) begin
                    count[15:8] <= i_pwdata[7:0];
                end
            end else if (special_clear) begin
                count <= COUNT_ZERO;
            end else if (inc) begin
                count <= count + 16'h0001;
            end
        end
    end

    // Sticky flag; a set in the same cycle as a clear wins
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            overflow_flag <= FLAG_RESET;
        end else if (i_ce) begin
            if (wr_access && reg_hit(i_paddr, IDX_PERIPHERAL_FLAG_REG)) begin
                overflow_flag <= i_pwdata[OVERFLOW_FLAG_BIT] | overflow_set;
            end else if (overflow_set) begin
                overflow_flag <= 1'b1;
            end
        end
    end

    // Interrupt enable bit
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            overflow_irq_enable <= ENABLE_RESET;
        end else if (wr_access && reg_hit(i_paddr, IDX_PERIPHERAL_ENABLE_REG)) begin
            overflow_irq_enable <= i_pwdata[OVERFLOW_IRQ_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    assign addr_mapped = reg_hit(i_paddr, IDX_COUNT_LOW_BYTE)
                       | reg_hit(i_paddr, IDX_COUNT_HIGH_BYTE)
                       | reg_hit(i_paddr, IDX_TIMER_ONE_CONTROL)
                       | reg_hit(i_paddr, IDX_PERIPHERAL_FLAG_REG)
                       | reg_hit(i_paddr, IDX_PERIPHERAL_ENABLE_REG);

    // Byte taken from the clocked count, so it is never torn
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (reg_hit(i_paddr, IDX_COUNT_LOW_BYTE)) begin
            next_prdata[7:0] = count[7:0];
        end else if (reg_hit(i_paddr, IDX_COUNT_HIGH_BYTE)) begin
            next_prdata[7:0] = count[15:8];
        end else if (reg_hit(i_paddr, IDX_TIMER_ONE_CONTROL)) begin
            next_prdata[CTL_W-1:0] = ctrl;
        end else if (reg_hit(i_paddr, IDX_PERIPHERAL_FLAG_REG)) begin
            next_prdata[OVERFLOW_FLAG_BIT] = overflow_flag;
        end else if (reg_hit(i_paddr, IDX_PERIPHERAL_ENABLE_REG)) begin
            next_prdata[OVERFLOW_IRQ_ENABLE_BIT] = overflow_irq_enable;
        end
    end

    // Read data captured in the setup cycle, held through the access
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_ce && i_psel && !i_penable) begin
            o_prdata <= next_prdata;
        end
    end

    // Zero wait states while the clock enable is high
    assign o_pready  = i_psel & i_penable & i_ce;
    assign o_pslverr = i_psel & i_penable & i_ce & ~addr_mapped;

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Oscillator stays on in sleep; pins switch to input duty
    assign o_osc_run             = osc_enable_bit;
    assign o_pins_as_inputs      = osc_enable_bit;
    assign o_osc_output_pin      = 1'b0;
    assign o_osc_output_pin_oe_n = 1'b1;

    assign o_overflow_irq   = overflow_flag & overflow_irq_enable;
    // Only the unsynchronised counter can still overflow in sleep
    assign o_wake           = o_overflow_irq & i_sleep & async_mode;
    assign o_timebase_valid = ~async_mode;
    assign o_count          = count;

endmodule

// ### shared/tmc_pkg.sv
// Shared constants for the sixteen-bit timer/counter block
package tmc_pkg;

    // Printed register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_PERIPHERAL_FLAG_REG   = 8'h0c;
    localparam logic [7:0]  IDX_COUNT_LOW_BYTE        = 8'h0e;
    localparam logic [7:0]  IDX_COUNT_HIGH_BYTE       = 8'h0f;
    localparam logic [7:0]  IDX_TIMER_ONE_CONTROL     = 8'h10;
    localparam logic [7:0]  IDX_PERIPHERAL_ENABLE_REG = 8'h8c;
    localparam int          APB_ADDR_W                = 12;

    // Control register field positions
    localparam int          CTL_TIMER_ON_BIT          = 0;
    localparam int          CTL_CLOCK_SOURCE_SELECT   = 1;
    localparam int          CTL_SYNC_DISABLE_BIT      = 2;
    localparam int          CTL_OSC_ENABLE_BIT        = 3;
    localparam int          CTL_PRESCALE_LSB          = 4;
    localparam int          CTL_PRESCALE_MSB          = 5;
    localparam int          CTL_W                     = 6;

    // Flag and enable register field positions
    localparam int          OVERFLOW_FLAG_BIT         = 0;
    localparam int          OVERFLOW_IRQ_ENABLE_BIT   = 0;

    // Values after power-on reset
    localparam logic [5:0]  CTL_RESET                 = 6'h00;
    localparam logic        FLAG_RESET                = 1'b0;
    localparam logic        ENABLE_RESET              = 1'b0;

    // Count limits and prescaler size
    localparam logic [15:0] COUNT_ALL_ONES            = 16'hffff;
    localparam logic [15:0] COUNT_ZERO                = 16'h0000;
    localparam int          PRESCALE_W                = 3;
    localparam logic [2:0]  PRESCALE_RESET            = 3'h0;

    // Synchroniser depth for pin inputs
    localparam int          SYNC_STAGES               = 2;

    // Internal phase clocks, Gray coded; one instruction cycle is four phases
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } tmc_phase_t;

endpackage

// ### rtl/tmc_pin_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module tmc_pin_sync
    import tmc_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    meta[g]   <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else if (i_ce) begin
                    meta[g]   <= i_async[g];
                    o_sync[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule

// ### bench/tmc_clk_source.sv
// Behavioural external clock source for the counter input pins
`timescale 1ns/1ns
module tmc_clk_source #(
    parameter int HALF_NS = 130
) (
    input  wire logic i_run,
    output logic      o_pin,
    output int        o_rises
);
    ////////////////////////////////////////////////////////////////////////
    // Whole pulses only while asked; the line stands low between bursts
    initial begin
        o_pin = 1'b0;
        o_rises = 0;
        forever begin
            wait (i_run);
            #HALF_NS o_pin = 1'b1;   // High well over two system clocks
            o_rises = o_rises + 1;
            #HALF_NS o_pin = 1'b0;   // Low well over two system clocks
        end
    end
endmodule

// ### bench/tmc_timer_assertions.sv
// Port-level checks for the timer/counter, attached by bind
`timescale 1ns/1ns
module tmc_timer_checker
    import tmc_pkg::*;
(
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [APB_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]           i_pwdata,
    input  wire logic                  i_sleep,
    input  wire logic                  i_special_event,
    input  wire logic                  o_osc_run,
    input  wire logic                  o_pins_as_inputs,
    input  wire logic                  o_osc_output_pin,
    input  wire logic                  o_osc_output_pin_oe_n,
    input  wire logic                  o_overflow_irq,
    input  wire logic                  o_wake,
    input  wire logic                  o_timebase_valid,
    input  wire logic [15:0]           o_count
);
    localparam logic [11:0] CTL_A = 12'(IDX_TIMER_ONE_CONTROL * 4);
    localparam logic [11:0] LOW_A = 12'(IDX_COUNT_LOW_BYTE * 4);
    logic [5:0]  ctl;
    logic [15:0] cnt_q;
    logic        wr_any;
    logic        cnt_wr;
    logic        stepped;
    logic        async_mode;

    ////////////////////////////////////////////////////////////////////////
    // Decoded bus writes; the control shadow follows them edge for edge
    assign wr_any = i_psel && i_penable && i_pwrite && i_ce;
    assign cnt_wr = wr_any && (i_paddr[11:3] == 9'h007);
    assign stepped = (o_count == 16'(cnt_q + 16'h0001));
    assign async_mode = ctl[1] && ctl[2];

    // Shadow of the control register
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) ctl <= 6'h00;
        else if (wr_any && i_paddr == CTL_A) ctl <= i_pwdata[5:0];
    end

    // Last count, to spot single steps
    always_ff @(posedge i_clk_sys) begin
        cnt_q <= o_count;
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Timer mode steps never closer than one instruction cycle
    sequence s_hold3;
        !stepped [*3];
    endsequence

    a_count_steps: assert property ($changed(o_count) && !$past(cnt_wr)
        && !$past(i_special_event) |-> stepped)
        else $error("count moved by other than one");
    a_off_holds: assert property (!ctl[0] && !cnt_wr && !i_special_event
        |=> $stable(o_count))
        else $error("count moved while timer off");
    a_timer_pace: assert property (!ctl[1] && stepped |=> s_hold3)
        else $error("timer mode stepped faster than four clocks");
    a_sleep_holds: assert property (i_sleep && !async_mode && !cnt_wr
        && !i_special_event |=> $stable(o_count))
        else $error("count moved in sleep outside asynchronous mode");
    a_async_wakes: assert property (o_wake == (o_overflow_irq && i_sleep && async_mode))
        else $error("wake does not match irq, sleep and mode");
    a_timebase_mode: assert property (o_timebase_valid == !async_mode)
        else $error("time base valid wrong for mode");
    a_osc_pins: assert property (o_osc_run == ctl[3] && o_pins_as_inputs == ctl[3]
        && o_osc_output_pin_oe_n && !o_osc_output_pin)
        else $error("oscillator enable outputs wrong");
    a_special_clears: assert property (i_special_event && !cnt_wr && !async_mode
        |=> o_count == 16'h0000)
        else $error("special event did not clear count");
    a_write_wins: assert property (cnt_wr && i_special_event && i_paddr == LOW_A
        |=> o_count[7:0] == $past(i_pwdata[7:0]))
        else $error("special event beat a count write");
    a_irq_holds: assert property (o_overflow_irq && !wr_any |=> o_overflow_irq)
        else $error("interrupt dropped without a write");
endmodule

bind tmc_timer tmc_timer_checker u_chk (
    .i_clk_sys, .i_rst_n, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_sleep, .i_special_event, .o_osc_run, .o_pins_as_inputs, .o_osc_output_pin_oe_n,
    .o_osc_output_pin, .o_overflow_irq, .o_wake, .o_timebase_valid, .o_count
);

// ### bench/tmc_timer_tb.sv
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ns
module tmc_timer_tb
    import tmc_pkg::*;
;
    localparam logic [11:0] A_FLG = 12'(IDX_PERIPHERAL_FLAG_REG * 4);
    localparam logic [11:0] A_LO  = 12'(IDX_COUNT_LOW_BYTE * 4);
    localparam logic [11:0] A_HI  = 12'(IDX_COUNT_HIGH_BYTE * 4);
    localparam logic [11:0] A_CTL = 12'(IDX_TIMER_ONE_CONTROL * 4);
    localparam logic [11:0] A_EN  = 12'(IDX_PERIPHERAL_ENABLE_REG * 4);
    logic        clk, rst_n, ce, psel, penable, pwrite, sleep, spec, run, osc_sel;
    logic        pready, pslverr, rerr, src, irq, wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] count, v, base;
    int          error_cnt, comparisons, seed, cyc, rises, n, p;

    tmc_clk_source src_model (.i_run(run), .o_pin(src), .o_rises(rises));

    tmc_timer dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_ext_clock_pin(osc_sel ? 1'b0 : src),
        .i_osc_input_pin(osc_sel ? src : 1'b0), .i_sleep(sleep), .i_special_event(spec),
        .o_osc_run(), .o_pins_as_inputs(), .o_osc_output_pin(), .o_osc_output_pin_oe_n(),
        .o_overflow_irq(irq), .o_wake(wake), .o_timebase_valid(), .o_count(count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and check helpers; each bus cycle ends with one idle clock
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic sp);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        spec <= sp;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        spec <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 8'h00, 1'b0);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // High, low, high again; retry when the two highs differ
    task automatic rdcnt();
        logic [7:0] h;
        do begin
            rd(A_HI);
            h = rdata[7:0];
            rd(A_LO);
            v[7:0] = rdata[7:0];
            rd(A_HI);
            v[15:8] = rdata[7:0];
        end while (v[15:8] !== h);
    endtask

    // Only called with the timer stopped, so no write contention
    task automatic setcnt(input logic [15:0] c);
        wr(A_LO, c[7:0]);
        wr(A_HI, c[15:8]);
    endtask

    task automatic pulses(input int m);
        int t;
        t = rises + m;
        run <= 1'b1;
        while (rises < t) @(posedge clk);
        run <= 1'b0;
        repeat (12) @(posedge clk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, sleep, spec, run, osc_sel} = 8'h00;
        {paddr, pwdata} = 44'h0;
        ce = 1'b1;
        {error_cnt, comparisons, cyc} = 96'h0;
        seed = 32'ha577;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(A_FLG);
        chk("flag reset", 32'h0, rdata);
        rd(A_CTL);
        chk("control reset", 32'h0, rdata);
        rd(A_EN);
        chk("enable reset", 32'h0, rdata);
        rd(12'h044);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdata);
        // Control bits read back, upper two read zero
        repeat (4) begin
            p = $random(seed);
            wr(A_CTL, p[7:0] & 8'hfe);
            rd(A_CTL);
            chk("control readback", {24'h0, p[7:0] & 8'h3e}, rdata);
        end
        // Timer mode at each ratio: twenty steps expected per window
        for (int ps = 0; ps < 4; ps++) begin
            base = 16'($random(seed));
            setcnt(base);
            wr(A_CTL, 8'(ps << 4) | 8'h01);
            repeat (80 << ps) @(posedge clk);
            wr(A_CTL, 8'h00);
            rdcnt();
            chk("timer pace", 32'h1, {31'h0, 16'(v - base) inside {[19:21]}});
        end
        // Wrap sets the flag; enable masks the interrupt
        wr(A_FLG, 8'h00);
        wr(A_EN, 8'h01);
        setcnt(16'hfffe);
        wr(A_CTL, 8'h01);
        repeat (16) @(posedge clk);
        chk("irq after wrap", 32'h1, {31'h0, irq});
        wr(A_EN, 8'h00);
        chk("irq masked", 32'h0, {31'h0, irq});
        // Clock enable low freezes a running count
        ce <= 1'b0;
        @(posedge clk);
        base = count;
        repeat (20) @(posedge clk);
        chk("frozen count", 32'(base), 32'(count));
        ce <= 1'b1;
        wr(A_CTL, 8'h00);
        rdcnt();
        chk("count wrapped", 32'h1, {31'h0, v inside {[0:15]}});
        rd(A_FLG);
        chk("flag held", 32'h1, rdata);
        wr(A_FLG, 8'h00);
        rd(A_FLG);
        chk("flag cleared", 32'h0, rdata);
        // Counter mode over every pin and sync choice, random ratio and count
        for (int i = 0; i < 6; i++) begin
            p = $random(seed);
            p[3:2] = 2'(i);
            base = 16'($random(seed));
            osc_sel <= p[3];
            setcnt(base);
            wr(A_CTL, {2'b00, p[5:4], p[3:2], 2'b10});
            if (p[3]) repeat (50) @(posedge clk);
            wr(A_CTL, {2'b00, p[5:4], p[3:2], 2'b11});
            n = (2 + int'(p[8:6])) << p[5:4];
            pulses(n);
            wr(A_CTL, {2'b00, p[5:4], p[3:2], 2'b10});
            rdcnt();
            chk("counted edges", 32'(16'(base + 16'(n >> p[5:4]))), 32'(v));
        end
        osc_sel <= 1'b0;
        // Sleep: synchronised mode holds, asynchronous mode counts and wakes
        setcnt(16'h0100);
        wr(A_CTL, 8'h03);
        sleep <= 1'b1;
        pulses(6);
        sleep <= 1'b0;
        wr(A_CTL, 8'h00);
        rdcnt();
        chk("sleep sync hold", 32'h0100, 32'(v));
        setcnt(16'hfffd);
        wr(A_FLG, 8'h00);
        wr(A_EN, 8'h01);
        wr(A_CTL, 8'h07);
        sleep <= 1'b1;
        pulses(8);
        chk("wake", 32'h1, {31'h0, wake});
        sleep <= 1'b0;
        wr(A_CTL, 8'h00);
        rdcnt();
        chk("async sleep count", 32'h0005, 32'(v));
        // Special event clear, no flag, and a coinciding write wins
        setcnt(16'hffff);
        wr(A_FLG, 8'h00);
        spec <= 1'b1;
        @(posedge clk);
        spec <= 1'b0;
        @(posedge clk);
        chk("special clear", 32'h0, 32'(count));
        rd(A_FLG);
        chk("no flag on clear", 32'h0, rdata);
        setcnt(16'h5678);
        apb(1'b1, A_LO, 8'h9a, 1'b1);
        rdcnt();
        chk("write wins", 32'h569a, 32'(v));
        // Reset with the timer stopped clears control but keeps the count
        wr(A_CTL, 8'h3a);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(A_CTL);
        chk("control after reset", 32'h0, rdata);
        rdcnt();
        chk("count kept", 32'h569a, 32'(v));
        give_verdict();
    end
endmodule
